/* File: inc/accd_pkg.sv */
/*
 Constants, operation codes and helper functions for the 40-bit
 accumulator addition datapath.
 Assumes a single 100 MHz core clock with a synchronous reset.
*/
// Function
// RL1 - Legacy mode: pre-add shift acts as wide mode, no post-shift overflow handling.
// RL2 - Add-with-carry: destination = source + memory operand + carry flag, 40 bits.
// RL3 - Unsigned qualifier zero-extends the memory operand to 40 bits.
// RL4 - Otherwise sign-extend when sign-extension mode set, else zero-extend.
// RL5 - Overflow point and carry position follow the wide overflow mode bit.
// RL6 - On overflow, saturate when saturation mode set; set destination overflow flag.
// RL7 - Pre-add operand shift behaves as the signed arithmetic shift.
// RL8 - Shifted memory-operand additions use the 40-bit shifter path.
// RL9 - Long word: addressed word is high half; low half at addr+1 even, addr-1 odd.
// RL10 - Two-memory addition: both words shifted left 16, extended, summed to accumulator.
// RL11 - Memory-plus-constant: both extended, shifted up 16, result written back.
// RL12 - Memory-plus-constant: overflow at bit 31 sets accumulator zero flag.
// RL13 - Memory-plus-constant: carry taken from carry out of bit 31.
// RL14 - Memory-plus-constant with saturation: clamp to 16-bit positive or negative limit.
// RL15 - Long-word addition completes in one cycle, no pairing.
// RL16 - Every variant is accepted back to back, as in a repeat loop.
// RL17 - Plain and long-word additions are 40 bits in the arithmetic path.
// RL18 - Wide mode: overflow and carry at bit 39; otherwise bit 31.
package accd_pkg;
  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int SH_W = 6;
  localparam int ADDR_W = 23;
  localparam int ACC_N = 4;
  localparam int SEL_W = 2;
  localparam int HI_SHIFT = 16;
  localparam int NARROW_MSB = 31;
  localparam int WIDE_MSB = 39;
  localparam logic signed [SH_W-1:0] LEG_WRAP_LO = -6'sd32;
  localparam logic signed [SH_W-1:0] LEG_WRAP_HI = -6'sd17;
  localparam logic signed [SH_W-1:0] LEG_WRAP_ADD = 6'sd16;
  localparam logic [ACC_W-1:0] SAT_POS_WIDE = 40'h7fffffffff;
  localparam logic [ACC_W-1:0] SAT_NEG_WIDE = 40'h8000000000;
  localparam logic [ACC_W-1:0] SAT_POS_NARROW = 40'h007fffffff;
  localparam logic [ACC_W-1:0] SAT_NEG_NARROW = 40'hff80000000;
  localparam logic [WORD_W-1:0] SAT_POS_WORD = 16'h7fff;
  localparam logic [WORD_W-1:0] SAT_NEG_WORD = 16'h8000;
  localparam logic [SEL_W-1:0] ACC_ZERO = 2'h0;

  typedef enum logic [2:0] {
    ACCD_OP_PLAIN = 3'b000,
    ACCD_OP_CARRY = 3'b001,
    ACCD_OP_SHIFT = 3'b010,
    ACCD_OP_DBL = 3'b011,
    ACCD_OP_DUAL_MEM = 3'b100,
    ACCD_OP_MEM_K16 = 3'b101
  } accd_op_t;

  // Widen a 16-bit word, sign-filling only when asked
  function automatic logic [ACC_W-1:0] accd_ext16(
    input logic [WORD_W-1:0] w, input logic sgn);
    accd_ext16 = {{(ACC_W-WORD_W){sgn & w[WORD_W-1]}}, w};
  endfunction

  // Result fits a signed field whose top bit is msb
  function automatic logic accd_fits(input logic [ACC_W:0] s, input int msb);
    logic [ACC_W:0] top;
    top = s >> msb;
    accd_fits = (top == '0) || (top == {(ACC_W+1){1'b1}} >> msb);
  endfunction
endpackage

/* File: inc/accd_sh_if.sv */
/*
 Carrier between the datapath and its signed shifter.
 Assumes both ends sit in the same clock domain; purely combinational.
*/
`timescale 1ns/10ps
interface accd_sh_if;
  import accd_pkg::*;
  logic [ACC_W-1:0] val;
  logic signed [SH_W-1:0] amt;
  logic legacy;
  logic [ACC_W-1:0] res;
  modport ctl (output val, output amt, output legacy, input res);
  modport sh (input val, input amt, input legacy, output res);
endinterface

/* File: design/accd_shift.sv */
/*
 Signed arithmetic shifter, 40 bits, shift count -32..+31.
 Assumes the caller has already extended the operand to 40 bits.
*/
`timescale 1ns/10ps
module accd_shift (
  accd_sh_if.sh sh // Operand, count and result
);
  import accd_pkg::*;
  logic signed [SH_W-1:0] eff;
  logic signed [ACC_W-1:0] v;

  always_comb begin
    eff = sh.amt;
    // Legacy counts -32..-17 fold modulo 16 into -16..-1
    if (sh.legacy && sh.amt >= LEG_WRAP_LO && sh.amt <= LEG_WRAP_HI) begin
      eff = SH_W'(sh.amt + LEG_WRAP_ADD); // RL1
    end
  end

  // Same arithmetic shift as the stand-alone signed shift
  always_comb begin
    v = sh.val;
    if (eff[SH_W-1]) begin
      sh.res = ACC_W'(v >>> (-eff)); // RL7
    end else begin
      sh.res = ACC_W'(v <<< eff); // RL7
    end
  end
endmodule

/* File: design/accd_top.sv */
/*
 40-bit accumulator addition datapath: operand extension, pre-add shift,
 add, overflow detection, saturation, carry and overflow flags.
 Assumes the decoder presents one operation per cycle with operands
 already fetched; results appear one cycle after op_valid.
*/
`timescale 1ns/10ps
module accd_top (
  input wire logic clk, // Core clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic op_valid, // Operation presented this cycle
  input wire accd_pkg::accd_op_t op_kind, // Addition variant
  input wire logic [accd_pkg::SEL_W-1:0] dst_sel, // Destination accumulator
  input wire logic [accd_pkg::ACC_W-1:0] source_accumulator, // Source value
  input wire logic [accd_pkg::WORD_W-1:0] mem_word, // Addressed word
  input wire logic [accd_pkg::WORD_W-1:0] mem_word2, // Second/pair word
  input wire logic [accd_pkg::WORD_W-1:0] sixteen_bit_constant, // Constant
  input wire logic [accd_pkg::SH_W-1:0] shift_amt, // Signed shift count
  input wire logic uns_qual, // Unsigned qualifier on memory operand
  input wire logic [accd_pkg::ADDR_W-1:0] lmem_addr, // Long-word address
  input wire logic sign_extension_mode, // Sign-extend operands
  input wire logic wide_overflow_mode, // 40-bit overflow and carry
  input wire logic data_saturation_mode, // Saturate on overflow
  input wire logic legacy_compat_mode, // Legacy shift behaviour
  input wire logic [accd_pkg::ACC_N-1:0] ovf_clr, // Clear overflow flags
  input wire logic carry_load, // Load carry flag
  input wire logic carry_load_val, // Value for carry load
  output logic [accd_pkg::ADDR_W-1:0] lsw_addr, // Low-half word address
  output logic [accd_pkg::ACC_W-1:0] destination_accumulator, // Result
  output logic acc_wr, // Accumulator write strobe
  output logic [accd_pkg::SEL_W-1:0] acc_wr_sel, // Accumulator written
  output logic [accd_pkg::WORD_W-1:0] mem_result, // Write-back word
  output logic mem_wr, // Memory write strobe
  output logic carry_flag, // Carry status
  output logic [accd_pkg::ACC_N-1:0] acc_ovf_flags, // Sticky overflow flags
  output logic dest_acc_overflow_flag, // Overflow on last result
  output logic acc_zero_overflow_flag // Accumulator zero overflow flag
);
  import accd_pkg::*;

  accd_sh_if shi ();
  accd_shift u_shift (.sh(shi.sh));

  logic [ACC_W-1:0] mem_ext, dbl_ext, op_a, op_b, sat_val;
  logic [ACC_W:0] sum;
  logic [NARROW_MSB+1:0] low_sum;
  logic cin, ovf, car, sgn_true;
  logic is_k16, use_wide;

  logic [ACC_W-1:0] acc_q, acc_d;
  logic acc_wr_q;
  logic [SEL_W-1:0] sel_q;
  logic [WORD_W-1:0] memw_q, memw_d;
  logic mem_wr_q;
  logic carry_q;
  logic [ACC_N-1:0] ovf_q;
  logic dovf_q;
  logic [ADDR_W-1:0] lsw_q;

  // Unsigned forces zero fill of mem_ext; dbl_ext follows the mode alone
  always_comb begin
    mem_ext = accd_ext16(mem_word, ~uns_qual & sign_extension_mode); // RL3 RL4
    dbl_ext = {{(ACC_W-2*WORD_W){sign_extension_mode & mem_word[WORD_W-1]}},
               mem_word, mem_word2}; // RL9
  end

  assign shi.val = mem_ext;
  assign shi.amt = shift_amt;
  assign shi.legacy = legacy_compat_mode;

  // Operand selection per variant
  always_comb begin
    op_a = source_accumulator;
    op_b = mem_ext;
    cin = 1'b0;
    case (op_kind)
      ACCD_OP_PLAIN: op_b = mem_ext; // RL17
      ACCD_OP_CARRY: begin
        op_b = mem_ext;
        cin = carry_q; // RL2
      end
      ACCD_OP_SHIFT: op_b = shi.res; // RL8 RL1
      ACCD_OP_DBL: op_b = dbl_ext; // RL17
      ACCD_OP_DUAL_MEM: begin
        op_a = accd_ext16(mem_word, sign_extension_mode) << HI_SHIFT; // RL10
        op_b = accd_ext16(mem_word2, sign_extension_mode) << HI_SHIFT; // RL10
      end
      ACCD_OP_MEM_K16: begin
        op_a = accd_ext16(mem_word, sign_extension_mode) << HI_SHIFT; // RL11
        op_b = accd_ext16(sixteen_bit_constant, sign_extension_mode)
               << HI_SHIFT; // RL11
      end
      default: op_b = mem_ext;
    endcase
  end

  // Adder, overflow and carry; constant add always works at bit 31
  always_comb begin
    is_k16 = (op_kind == ACCD_OP_MEM_K16);
    use_wide = wide_overflow_mode & ~is_k16; // RL5 RL12
    sum = {op_a[ACC_W-1], op_a} + {op_b[ACC_W-1], op_b} + (ACC_W+1)'(cin);
    low_sum = {1'b0, op_a[NARROW_MSB:0]} + {1'b0, op_b[NARROW_MSB:0]}
              + (NARROW_MSB+2)'(cin);
    sgn_true = sum[ACC_W];
    if (use_wide) begin
      ovf = ~accd_fits(sum, WIDE_MSB); // RL18
      car = sum[ACC_W] ^ op_a[ACC_W-1] ^ op_b[ACC_W-1]; // RL18
      sat_val = sgn_true ? SAT_NEG_WIDE : SAT_POS_WIDE; // RL6
    end else begin
      ovf = ~accd_fits(sum, NARROW_MSB); // RL18 RL12
      car = low_sum[NARROW_MSB+1]; // RL18 RL13
      sat_val = sgn_true ? SAT_NEG_NARROW : SAT_POS_NARROW; // RL6
    end
  end

  always_comb begin
    acc_d = sum[ACC_W-1:0]; // RL17
    if (ovf && data_saturation_mode) begin
      acc_d = sat_val; // RL6
    end
    memw_d = sum[NARROW_MSB:HI_SHIFT]; // RL11
    if (ovf && data_saturation_mode) begin
      memw_d = sgn_true ? SAT_NEG_WORD : SAT_POS_WORD; // RL14
    end
  end

  // One result per accepted operation, every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= '0;
      acc_wr_q <= 1'b0;
      sel_q <= '0;
      dovf_q <= 1'b0;
    end else begin
      acc_wr_q <= op_valid & ~is_k16; // RL15 RL16
      if (op_valid && !is_k16) begin
        acc_q <= acc_d;
        sel_q <= dst_sel;
        dovf_q <= ovf; // RL6
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      memw_q <= '0;
      mem_wr_q <= 1'b0;
    end else begin
      mem_wr_q <= op_valid & is_k16; // RL16
      if (op_valid && is_k16) begin
        memw_q <= memw_d; // RL11
      end
    end
  end

  // Low half follows the address parity
  always_ff @(posedge clk) begin
    if (rst) begin
      lsw_q <= '0;
    end else if (lmem_addr[0]) begin
      lsw_q <= lmem_addr - ADDR_W'(1); // RL9
    end else begin
      lsw_q <= lmem_addr + ADDR_W'(1); // RL9
    end
  end

  // Hardware update wins over an external load in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_q <= 1'b0;
    end else if (op_valid) begin
      carry_q <= car; // RL5 RL13
    end else if (carry_load) begin
      carry_q <= carry_load_val;
    end
  end

  // Sticky flags: a set beats a clear arriving together
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= '0;
    end else begin
      for (int i = 0; i < ACC_N; i++) begin
        if (op_valid && ovf && !is_k16 && dst_sel == SEL_W'(i)) begin
          ovf_q[i] <= 1'b1; // RL6
        end else if (op_valid && ovf && is_k16 && ACC_ZERO == SEL_W'(i)) begin
          ovf_q[i] <= 1'b1; // RL12
        end else if (ovf_clr[i]) begin
          ovf_q[i] <= 1'b0;
        end
      end
    end
  end

  assign destination_accumulator = acc_q;
  assign acc_wr = acc_wr_q;
  assign acc_wr_sel = sel_q;
  assign mem_result = memw_q;
  assign mem_wr = mem_wr_q;
  assign carry_flag = carry_q;
  assign acc_ovf_flags = ovf_q;
  assign dest_acc_overflow_flag = dovf_q;
  assign acc_zero_overflow_flag = ovf_q[ACC_ZERO];
  assign lsw_addr = lsw_q;

  sequence s_acc_op;
    op_valid && !is_k16;
  endsequence

  sequence s_k16_op;
    op_valid && is_k16;
  endsequence

  a_acc_one_cycle: assert property (@(posedge clk) disable iff (rst) // RL15
    s_acc_op |=> acc_wr && acc_wr_sel == $past(dst_sel))
    else $error("accumulator result not written after one cycle");

  a_carry_add_sum: assert property (@(posedge clk) disable iff (rst) // RL2
    op_valid && op_kind == ACCD_OP_CARRY && !ovf |=>
      destination_accumulator == $past(source_accumulator) + $past(mem_ext)
      + ACC_W'($past(carry_q)))
    else $error("add with carry result wrong");

  a_uns_zero_fill: assert property (@(posedge clk) disable iff (rst) // RL3
    op_valid && uns_qual && op_kind == ACCD_OP_PLAIN |->
      mem_ext[ACC_W-1:WORD_W] == '0)
    else $error("unsigned operand not zero extended");

  a_sat_wide_pos: assert property (@(posedge clk) disable iff (rst) // RL6
    s_acc_op ##0 (ovf && data_saturation_mode && wide_overflow_mode
      && !sgn_true) |=> destination_accumulator == SAT_POS_WIDE
      && dest_acc_overflow_flag)
    else $error("wide positive saturation missing");

  a_ovf_flag_set: assert property (@(posedge clk) disable iff (rst) // RL6
    s_acc_op ##0 ovf |=> acc_ovf_flags[$past(dst_sel)])
    else $error("destination overflow flag not set");

  a_k16_zero_flag: assert property (@(posedge clk) disable iff (rst) // RL12
    s_k16_op ##0 ovf |=> acc_zero_overflow_flag && mem_wr)
    else $error("constant add overflow flag missing");

  a_k16_sat_neg: assert property (@(posedge clk) disable iff (rst) // RL14
    s_k16_op ##0 (ovf && data_saturation_mode && sgn_true) |=>
      mem_result == SAT_NEG_WORD)
    else $error("constant add negative clamp wrong");

  a_k16_carry31: assert property (@(posedge clk) disable iff (rst) // RL13
    s_k16_op |=> carry_flag == $past(low_sum[NARROW_MSB+1]))
    else $error("constant add carry not from bit 31");

  a_lsw_parity: assert property (@(posedge clk) disable iff (rst) // RL9
    !lmem_addr[0] |=> lsw_addr == $past(lmem_addr) + ADDR_W'(1))
    else $error("even long-word low address wrong");

  a_back_to_back: assert property (@(posedge clk) disable iff (rst) // RL16
    s_acc_op ##1 s_acc_op |-> acc_wr ##1 acc_wr)
    else $error("back-to-back additions dropped");

  // Checks below tie results to the inputs of the previous edge
  a_k16_write_strobe: assert property (@(posedge clk) disable iff (rst) // RL11
    s_k16_op |=> mem_wr && !acc_wr)
    else $error("constant add write strobe wrong");

  a_k16_sat_pos: assert property (@(posedge clk) disable iff (rst) // RL14
    s_k16_op ##0 (ovf && data_saturation_mode && !sgn_true) |=>
      mem_result == SAT_POS_WORD)
    else $error("constant add positive clamp wrong");

  a_k16_word_sum: assert property (@(posedge clk) disable iff (rst) // RL11
    s_k16_op ##0 !ovf |=> mem_result
      == WORD_W'($past(mem_word) + $past(sixteen_bit_constant)))
    else $error("constant add write-back word wrong");

  a_dual_low_zero: assert property (@(posedge clk) disable iff (rst) // RL10
    op_valid && op_kind == ACCD_OP_DUAL_MEM && !ovf |=>
      destination_accumulator[HI_SHIFT-1:0] == '0)
    else $error("two-word sum low half not zero");

  a_lsw_odd: assert property (@(posedge clk) disable iff (rst) // RL9
    lmem_addr[0] |=> lsw_addr == $past(lmem_addr) - ADDR_W'(1))
    else $error("odd long-word low address wrong");

  a_sat_narrow_neg: assert property (@(posedge clk) disable iff (rst) // RL6
    s_acc_op ##0 (ovf && data_saturation_mode && !wide_overflow_mode
      && sgn_true) |=> destination_accumulator == SAT_NEG_NARROW)
    else $error("narrow negative saturation missing");

  a_no_ovf_flag: assert property (@(posedge clk) disable iff (rst) // RL6
    s_acc_op ##0 !ovf |=> !dest_acc_overflow_flag)
    else $error("overflow flag set without overflow");

  a_flags_sticky: assert property (@(posedge clk) disable iff (rst) // RL6
    ovf_clr == '0 |=> (acc_ovf_flags & $past(acc_ovf_flags))
      == $past(acc_ovf_flags))
    else $error("overflow flag lost without clear");

  a_shift_zero: assert property (@(posedge clk) disable iff (rst) // RL7
    op_valid && op_kind == ACCD_OP_SHIFT && shift_amt == '0 && !ovf |=>
      destination_accumulator == $past(source_accumulator) + $past(mem_ext))
    else $error("zero-count shifted add wrong");

  a_wide_fit: assert property (@(posedge clk) disable iff (rst) // RL18
    s_acc_op ##0 (wide_overflow_mode && sum[ACC_W] == sum[WIDE_MSB]) |=>
      !dest_acc_overflow_flag)
    else $error("wide result flagged although it fits");
endmodule

/* File: bench/accd_fetch_model.sv */
/*
 Operand fetch model: data memory as seen by the decoder.
 Assumes word contents are a fixed scramble of the word address.
*/
`timescale 1ns/10ps
module accd_fetch_model (
  input wire logic [accd_pkg::ADDR_W-1:0] hi_addr, // Addressed word
  input wire logic [accd_pkg::ADDR_W-1:0] lo_addr, // Pair word
  output logic [accd_pkg::WORD_W-1:0] hi_word, // Word at hi_addr
  output logic [accd_pkg::WORD_W-1:0] lo_word // Word at lo_addr
);
  import accd_pkg::*;
  // Scrambled so that neighbouring words never look alike
  function automatic logic [WORD_W-1:0] rd(input logic [ADDR_W-1:0] a);
    return a[15:0] * 16'h9e37 ^ {a[22:16], 9'h0a5};
  endfunction
  assign hi_word = rd(hi_addr);
  assign lo_word = rd(lo_addr);
endmodule

/* File: bench/accd_top_test.sv */
/*
 Self-checking bench for the accumulator addition datapath.
 Assumes the fetch model supplies both halves of a long word.
*/
`timescale 1ns/10ps
module accd_top_test;
  import accd_pkg::*;
  typedef struct packed {
    accd_op_t kind;
    logic [39:0] src;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [5:0] amt;
    logic [4:0] md;
    logic [22:0] la;
  } accd_case_t;
  localparam int N_DIR = 9;
  // Mode bits: unsigned, sign, wide, saturate, legacy
  localparam accd_case_t DIR [N_DIR] = '{
    '{ACCD_OP_PLAIN, 40'h7fffffff, 16'h1, 16'h0, 6'h0, 5'b01010, 23'h0},
    '{ACCD_OP_SHIFT, 40'h0, 16'hf0, 16'h0, 6'h2c, 5'b10001, 23'h0},
    '{ACCD_OP_DBL, 40'h1, 16'h0, 16'h0, 6'h0, 5'b01000, 23'h101},
    '{ACCD_OP_MEM_K16, 40'h0, 16'h7fff, 16'h1, 6'h0, 5'b01010, 23'h0},
    '{ACCD_OP_MEM_K16, 40'h0, 16'hffff, 16'h1, 6'h0, 5'b01000, 23'h0},
    '{ACCD_OP_CARRY, 40'h0, 16'h0, 16'h0, 6'h0, 5'b10000, 23'h0},
    '{ACCD_OP_DUAL_MEM, 40'h0, 16'h8000, 16'h8000, 6'h0, 5'b00100, 23'h0},
    '{ACCD_OP_PLAIN, 40'hffffffffff, 16'h1, 16'h0, 6'h0, 5'b10100, 23'h0},
    '{ACCD_OP_PLAIN, 40'h0, 16'h8000, 16'h0, 6'h0, 5'b11000, 23'h0}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  accd_op_t kind = ACCD_OP_PLAIN;
  logic [1:0] dst = 2'h0;
  logic [39:0] src = 40'h0;
  logic [15:0] mw = 16'h0, mw2 = 16'h0, k = 16'h0;
  logic [5:0] amt = 6'h0;
  logic [22:0] lmem = 23'h0, lo_a = 23'h0;
  logic uq = 1'b0, sxm = 1'b0, m40 = 1'b0, sat = 1'b0, leg = 1'b0;
  logic [3:0] clr = 4'h0;
  logic cl = 1'b0, clv = 1'b0;
  logic [22:0] lsw;
  logic [39:0] acc;
  logic acc_wr, mem_wr, cy, dovf, zovf;
  logic [1:0] wsel;
  logic [15:0] mres, hw, lw;
  logic [3:0] flags;
  logic [39:0] e_acc = '0;
  logic [15:0] e_mres = '0;
  // Idle edge before the first step loads address 0 plus 1
  logic [22:0] e_lsw = 23'h1;
  logic [3:0] e_flags = '0;
  logic [1:0] e_sel = '0;
  logic e_cy = 1'b0, e_dovf = 1'b0, e_accwr = 1'b0, e_memwr = 1'b0;
  int n_fail = 0;
  int num_checks = 0;

  accd_top dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_kind(kind),
    .dst_sel(dst), .source_accumulator(src), .mem_word(mw),
    .mem_word2(mw2), .sixteen_bit_constant(k), .shift_amt(amt),
    .uns_qual(uq), .lmem_addr(lmem), .sign_extension_mode(sxm),
    .wide_overflow_mode(m40), .data_saturation_mode(sat),
    .legacy_compat_mode(leg), .ovf_clr(clr), .carry_load(cl),
    .carry_load_val(clv), .lsw_addr(lsw), .destination_accumulator(acc),
    .acc_wr(acc_wr), .acc_wr_sel(wsel), .mem_result(mres),
    .mem_wr(mem_wr), .carry_flag(cy), .acc_ovf_flags(flags),
    .dest_acc_overflow_flag(dovf), .acc_zero_overflow_flag(zovf));
  accd_fetch_model fetch (.hi_addr(lmem), .lo_addr(lo_a), .hi_word(hw),
    .lo_word(lw));

  initial begin
    forever begin
      #5 clk = ~clk;
    end
  end

  function automatic logic [39:0] ext(input logic [15:0] w, input logic sg);
    return {{24{sg & w[15]}}, w};
  endfunction
  function automatic logic [39:0] ash(input logic [39:0] x, input int c);
    if (c >= 0) return x << c;
    return 40'($signed(x) >>> -c);
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Outputs of the previous op are checked before the next is launched
  task automatic step(input int idx);
    accd_case_t c;
    logic [39:0] a, b, r;
    logic [40:0] s, u;
    logic [32:0] v;
    logic [3:0] setm;
    logic ov, cin, m;
    @(negedge clk);
    chk(40'(acc_wr), 40'(e_accwr));
    chk(40'(mem_wr), 40'(e_memwr));
    chk(acc, e_acc);
    chk(40'(wsel), 40'(e_sel));
    chk(40'(mres), 40'(e_mres));
    chk(40'(cy), 40'(e_cy));
    chk(40'(flags), 40'(e_flags));
    chk(40'(dovf), 40'(e_dovf));
    chk(40'(zovf), 40'(e_flags[0]));
    chk(40'(lsw), 40'(e_lsw));
    if (idx >= 0) c = DIR[idx];
    else c = 109'({$urandom, $urandom, $urandom, $urandom});
    op_valid = idx >= 0 || $urandom_range(4) != 0;
    kind = c.kind;
    src = c.src;
    amt = c.amt;
    {uq, sxm, m40, sat, leg} = c.md;
    dst = 2'($urandom);
    lmem = c.la;
    lo_a = c.la[0] ? c.la - 23'h1 : c.la + 23'h1;
    mw = c.w1;
    mw2 = c.w2;
    k = c.w2;
    cl = 1'($urandom);
    clv = 1'($urandom);
    clr = ($urandom_range(7) == 0) ? 4'($urandom) : 4'h0;
    #1;
    if (kind == ACCD_OP_DBL) begin
      mw = hw;
      mw2 = lw;
    end
    cin = kind == ACCD_OP_CARRY ? e_cy : 1'b0;
    m = m40 && kind != ACCD_OP_MEM_K16;
    a = src;
    b = ext(mw, sxm & ~uq);
    case (kind)
      ACCD_OP_SHIFT: begin
        if (leg && $signed(c.amt) < -6'sd16) c.amt = c.amt + 6'h10;
        b = ash(b, int'($signed(c.amt)));
      end
      ACCD_OP_DBL: b = {{8{sxm & mw[15]}}, mw, mw2};
      ACCD_OP_DUAL_MEM, ACCD_OP_MEM_K16: begin
        a = ext(mw, sxm) << 16;
        b = ext(kind == ACCD_OP_MEM_K16 ? k : mw2, sxm) << 16;
      end
      default: ;
    endcase
    s = {a[39], a} + {b[39], b} + 41'(cin);
    u = {1'b0, a} + {1'b0, b} + 41'(cin);
    v = {1'b0, a[31:0]} + {1'b0, b[31:0]} + 33'(cin);
    ov = m ? s[40] ^ s[39] : !(&s[40:31] || ~|s[40:31]);
    r = s[39:0];
    if (ov && sat) r = s[40] ? SAT_NEG_NARROW : SAT_POS_NARROW;
    if (ov && sat && m) r = s[40] ? SAT_NEG_WIDE : SAT_POS_WIDE;
    setm = 4'h0;
    if (op_valid) begin
      e_cy = m ? u[40] : v[32];
      if (kind == ACCD_OP_MEM_K16) begin
        e_mres = s[31:16];
        if (ov && sat) e_mres = s[40] ? 16'h8000 : 16'h7fff;
        setm[0] = ov;
      end else begin
        e_acc = r;
        e_sel = dst;
        e_dovf = ov;
        setm[dst] = ov;
      end
    end else if (cl) begin
      e_cy = clv;
    end
    e_flags = (e_flags & ~clr) | setm;
    e_accwr = op_valid && kind != ACCD_OP_MEM_K16;
    e_memwr = op_valid && kind == ACCD_OP_MEM_K16;
    e_lsw = lo_a;
  endtask

  initial begin
    void'($urandom(8455));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < N_DIR; i++) begin
      step(i);
    end
    for (int i = 0; i < 3000; i++) begin
      step(-1);
    end
    step(-1);
    give_verdict();
  end

  // Whole run takes about 30 us; a hang is cut well after that
  initial begin
    #100us;
    n_fail++;
    give_verdict();
  end
endmodule
